// >>> core/atc_regs.svh
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

// channel counts and widths
`define ATC_NUM_IN 8
`define ATC_NUM_OUT 4
`define ATC_HIST_DEPTH 9
`define ATC_MEM_WORDS 72
`define ATC_MEM_AW 7
`define ATC_SMP_W 12
`define ATC_DAC_W 10
`define ATC_REG_AW 6
`define ATC_REG_DW 16

// register word addresses
`define ATC_A_RESULT 6'h00
`define ATC_A_SET 6'h08
`define ATC_A_CODE 6'h0C
`define ATC_A_IN_GAIN 6'h10
`define ATC_A_IN_OFS 6'h18
`define ATC_A_OUT_GAIN 6'h20
`define ATC_A_OUT_OFS 6'h24
`define ATC_A_POINTS 6'h28
`define ATC_A_CTRL 6'h29

// control fields and reset values
`define ATC_CTRL_BOOT_BIT 0
`define ATC_POINTS_RST 4'h1
`define ATC_POINTS_MAX 4'h9
`define ATC_SMP_MAX 12'hFFF

// trim arithmetic
`define ATC_GAIN_DEN 32'sh00002710
`define ATC_GAIN_HALF 32'sh00001388
`define ATC_OFS_MAX 8'sh64
`define ATC_OFS_MIN (-8'sh64)

`endif

// >>> core/atc_pkg.sv
package atc_pkg;
   typedef logic signed [15:0] atc_gain_t;
   typedef logic signed [7:0] atc_ofs_t;
   typedef logic [11:0] atc_smp_t;
   typedef enum logic [1:0] {
      ATC_IDLE = 2'b00,
      ATC_READ = 2'b01,
      ATC_ACC = 2'b10,
      ATC_DONE = 2'b11
   } atc_state_e;
endpackage

// >>> core/atc_hist_mem.sv
`timescale 1ns/1ps
`include "atc_regs.svh"

module atc_hist_mem (
   input wire logic ref_clk, // clock
   input wire logic wr_en, // write strobe
   input wire logic [`ATC_MEM_AW-1:0] wr_addr, // write address
   input wire logic [`ATC_SMP_W-1:0] wr_data, // write data
   input wire logic [`ATC_MEM_AW-1:0] rd_addr, // read address
   output logic [`ATC_SMP_W-1:0] rd_data_q // registered read data
);
   logic [`ATC_SMP_W-1:0] mem [0:`ATC_MEM_WORDS-1];

   // write port
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // registered read port
   always_ff @(posedge ref_clk) begin
      rd_data_q <= mem[rd_addr];
   end
endmodule

// >>> core/atc_top.sv
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "atc_regs.svh"

// Overview of operation
// - four output channels, 10-bit converter code
// - set command carries channel, 12-bit value
// - set value drops two bits onto converter
// - output code held until next set or output trim write
// - zero trims give identity, 2048 is midscale
// - input scaled by one plus gain/10000
// - input trims apply only after cold boot
// - input offset trim added to reading
// - output scaled by one plus gain/10000
// - output offset clamped, added before converter
// - point count sets samples averaged per read
// - point count one returns latest sample
// - per-channel history, newest replaces oldest
// - input results are 12-bit unsigned

module atc_top (
   input wire logic ref_clk, // 25 MHz clock
   input wire logic reset, // synchronous, active high
   input wire logic [`ATC_REG_AW-1:0] reg_addr, // register word address
   input wire logic [`ATC_REG_DW-1:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [`ATC_REG_DW-1:0] reg_rdata, // read data, next cycle
   input wire logic sample_valid, // new input sample offered
   input wire logic [2:0] sample_chan, // input channel of sample
   input wire logic [`ATC_SMP_W-1:0] sample_data, // raw sample
   output logic sample_ready, // sample taken when high
   output logic [`ATC_DAC_W-1:0] dac_code0, // converter code ch 0
   output logic [`ATC_DAC_W-1:0] dac_code1, // converter code ch 1
   output logic [`ATC_DAC_W-1:0] dac_code2, // converter code ch 2
   output logic [`ATC_DAC_W-1:0] dac_code3 // converter code ch 3
);

   ////////////////////////////////////////////////////////////////////
   // trim arithmetic shared by both paths

   // gain, round, clamped offset, saturate to 12 bits
   function automatic atc_pkg::atc_smp_t trim12(
      input atc_pkg::atc_smp_t v,
      input atc_pkg::atc_gain_t g,
      input atc_pkg::atc_ofs_t o
   );
      logic signed [31:0] f;
      logic signed [31:0] p;
      logic signed [31:0] r;
      logic signed [31:0] s;
      atc_pkg::atc_ofs_t oc;
      f = `ATC_GAIN_DEN + 32'(g);
      p = $signed({20'h00000, v}) * f;
      if (p >= 0) begin
         r = (p + `ATC_GAIN_HALF) / `ATC_GAIN_DEN;
      end else begin
         r = -((-p + `ATC_GAIN_HALF) / `ATC_GAIN_DEN);
      end
      if (o > `ATC_OFS_MAX) begin
         oc = `ATC_OFS_MAX;
      end else if (o < `ATC_OFS_MIN) begin
         oc = `ATC_OFS_MIN;
      end else begin
         oc = o;
      end
      s = r + 32'(oc);
      if (s < 0) begin
         trim12 = 12'h000;
      end else if (s > $signed({20'h00000, `ATC_SMP_MAX})) begin
         trim12 = `ATC_SMP_MAX;
      end else begin
         trim12 = s[11:0];
      end
   endfunction

   // register address inside a block of channels
   function automatic logic in_block(
      input logic [`ATC_REG_AW-1:0] a,
      input logic [`ATC_REG_AW-1:0] base,
      input logic [`ATC_REG_AW-1:0] n
   );
      in_block = (a >= base) && (a < base + n);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // register storage

   atc_pkg::atc_gain_t in_gain_pend_q [`ATC_NUM_IN];
   atc_pkg::atc_ofs_t in_ofs_pend_q [`ATC_NUM_IN];
   atc_pkg::atc_gain_t in_gain_act_q [`ATC_NUM_IN];
   atc_pkg::atc_ofs_t in_ofs_act_q [`ATC_NUM_IN];
   atc_pkg::atc_gain_t out_gain_q [`ATC_NUM_OUT];
   atc_pkg::atc_ofs_t out_ofs_q [`ATC_NUM_OUT];
   atc_pkg::atc_smp_t set_q [`ATC_NUM_OUT];
   atc_pkg::atc_smp_t result_q [`ATC_NUM_IN];
   logic [`ATC_DAC_W-1:0] code_q [`ATC_NUM_OUT];
   logic [3:0] points_q;
   logic [`ATC_REG_DW-1:0] rdata_q;

   // write decode
   wire logic [2:0] wr_idx = reg_addr[2:0];
   wire logic wr_set = reg_wr &&
      in_block(reg_addr, `ATC_A_SET, 6'h04);
   wire logic wr_in_gain = reg_wr &&
      in_block(reg_addr, `ATC_A_IN_GAIN, 6'h08);
   wire logic wr_in_ofs = reg_wr &&
      in_block(reg_addr, `ATC_A_IN_OFS, 6'h08);
   wire logic wr_out_gain = reg_wr &&
      in_block(reg_addr, `ATC_A_OUT_GAIN, 6'h04);
   wire logic wr_out_ofs = reg_wr &&
      in_block(reg_addr, `ATC_A_OUT_OFS, 6'h04);
   wire logic wr_points = reg_wr && (reg_addr == `ATC_A_POINTS);
   wire logic cold_boot = reg_wr && (reg_addr == `ATC_A_CTRL) &&
      reg_wdata[`ATC_CTRL_BOOT_BIT];

   // pending input trims, written any time
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < `ATC_NUM_IN; i++) begin
         if (reset) begin
            in_gain_pend_q[i] <= 16'sh0000;
            in_ofs_pend_q[i] <= 8'sh00;
         end else begin
            if (wr_in_gain && wr_idx == 3'(i)) begin
               in_gain_pend_q[i] <= reg_wdata;
            end
            if (wr_in_ofs && wr_idx == 3'(i)) begin
               in_ofs_pend_q[i] <= reg_wdata[7:0];
            end
         end
      end
   end

   // active input trims, copied only on cold boot
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < `ATC_NUM_IN; i++) begin
         if (reset) begin
            in_gain_act_q[i] <= 16'sh0000;
            in_ofs_act_q[i] <= 8'sh00;
         end else if (cold_boot) begin
            in_gain_act_q[i] <= in_gain_pend_q[i];
            in_ofs_act_q[i] <= in_ofs_pend_q[i];
         end
      end
   end

   // output trims and held set values
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < `ATC_NUM_OUT; i++) begin
         if (reset) begin
            out_gain_q[i] <= 16'sh0000;
            out_ofs_q[i] <= 8'sh00;
            set_q[i] <= 12'h000;
         end else begin
            if (wr_out_gain && wr_idx[1:0] == 2'(i)) begin
               out_gain_q[i] <= reg_wdata;
            end
            if (wr_out_ofs && wr_idx[1:0] == 2'(i)) begin
               out_ofs_q[i] <= reg_wdata[7:0];
            end
            if (wr_set && wr_idx[1:0] == 2'(i)) begin
               set_q[i] <= reg_wdata[11:0];
            end
         end
      end
   end

   // averaging depth, clipped into 1..9
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         points_q <= `ATC_POINTS_RST;
      end else if (wr_points) begin
         if (reg_wdata[3:0] == 4'h0) begin
            points_q <= 4'h1;
         end else if (reg_wdata[15:4] != 12'h000 ||
                      reg_wdata[3:0] > `ATC_POINTS_MAX) begin
            points_q <= `ATC_POINTS_MAX;
         end else begin
            points_q <= reg_wdata[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output channels

   // trimmed code per channel, held between commands
   generate
      for (genvar c = 0; c < `ATC_NUM_OUT; c++) begin : g_out
         wire atc_pkg::atc_smp_t trimmed =
            trim12(set_q[c], out_gain_q[c], out_ofs_q[c]);
         always_ff @(posedge ref_clk) begin
            if (reset) begin
               code_q[c] <= 10'h000;
            end else begin
               code_q[c] <= trimmed[11:2];
            end
         end
      end
   endgenerate

   assign dac_code0 = code_q[0];
   assign dac_code1 = code_q[1];
   assign dac_code2 = code_q[2];
   assign dac_code3 = code_q[3];

   ////////////////////////////////////////////////////////////////////
   // input history and averaging

   atc_pkg::atc_state_e state_q;
   logic [3:0] wp_q [`ATC_NUM_IN];
   logic [3:0] fill_q [`ATC_NUM_IN];
   logic [2:0] ch_q;
   logic [3:0] base_q;
   logic [3:0] n_q;
   logic [3:0] k_q;
   logic [15:0] sum_q;
   atc_pkg::atc_smp_t mem_rd_data;

   assign sample_ready = (state_q == atc_pkg::ATC_IDLE);
   wire logic take = sample_valid && sample_ready;

   // address of history slot for one channel
   wire logic [3:0] wp_cur = wp_q[sample_chan];
   wire logic [`ATC_MEM_AW-1:0] wr_addr =
      7'(sample_chan) * 7'h09 + 7'(wp_cur);
   wire logic [3:0] fill_nxt =
      (fill_q[sample_chan] == 4'h9) ? 4'h9 : fill_q[sample_chan] + 4'h1;
   wire logic [3:0] n_take =
      (points_q < fill_nxt) ? points_q : fill_nxt;

   // k-th most recent slot, wrapping modulo depth
   wire logic [3:0] slot = (base_q >= k_q) ? base_q - k_q :
      base_q + 4'h9 - k_q;
   wire logic [`ATC_MEM_AW-1:0] rd_addr =
      7'(ch_q) * 7'h09 + 7'(slot);

   // rounded mean and trimmed result
   wire logic [15:0] avg = (sum_q + 16'(n_q >> 1)) / 16'(n_q);
   wire atc_pkg::atc_smp_t in_trim =
      trim12(avg[11:0], in_gain_act_q[ch_q],
             in_ofs_act_q[ch_q]);

   atc_hist_mem u_mem (
      .ref_clk(ref_clk),
      .wr_en(take),
      .wr_addr(wr_addr),
      .wr_data(sample_data),
      .rd_addr(rd_addr),
      .rd_data_q(mem_rd_data)
   );

   // write pointers and fill counts per channel
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < `ATC_NUM_IN; i++) begin
         if (reset) begin
            wp_q[i] <= 4'h0;
            fill_q[i] <= 4'h0;
         end else if (take && sample_chan == 3'(i)) begin
            wp_q[i] <= (wp_q[i] == 4'h8) ? 4'h0 : wp_q[i] + 4'h1;
            fill_q[i] <= fill_nxt;
         end
      end
   end

   // averaging sequencer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q <= atc_pkg::ATC_IDLE;
         ch_q <= 3'h0;
         base_q <= 4'h0;
         n_q <= 4'h1;
         k_q <= 4'h0;
         sum_q <= 16'h0000;
      end else begin
         unique case (state_q)
            atc_pkg::ATC_IDLE: begin
               if (take) begin
                  ch_q <= sample_chan;
                  base_q <= wp_cur;
                  n_q <= n_take;
                  k_q <= 4'h0;
                  sum_q <= 16'h0000;
                  state_q <= atc_pkg::ATC_READ;
               end
            end
            atc_pkg::ATC_READ: begin
               state_q <= atc_pkg::ATC_ACC;
            end
            atc_pkg::ATC_ACC: begin
               sum_q <= sum_q + 16'(mem_rd_data);
               if (k_q + 4'h1 == n_q) begin
                  state_q <= atc_pkg::ATC_DONE;
               end else begin
                  k_q <= k_q + 4'h1;
                  state_q <= atc_pkg::ATC_READ;
               end
            end
            atc_pkg::ATC_DONE: begin
               state_q <= atc_pkg::ATC_IDLE;
            end
         endcase
      end
   end

   // stored results per input channel
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < `ATC_NUM_IN; i++) begin
         if (reset) begin
            result_q[i] <= 12'h000;
         end else if (state_q == atc_pkg::ATC_DONE && ch_q == 3'(i)) begin
            result_q[i] <= in_trim;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read path

   logic [`ATC_REG_DW-1:0] rd_mux;
   wire logic wr_set_sel = in_block(reg_addr, `ATC_A_SET, 6'h04);

   // read selection, unmapped reads give zero
   always_comb begin
      rd_mux = 16'h0000;
      if (in_block(reg_addr, `ATC_A_RESULT, 6'h08)) begin
         rd_mux = {4'h0, result_q[wr_idx]};
      end else if (wr_set_sel) begin
         rd_mux = {4'h0, set_q[wr_idx[1:0]]};
      end else if (in_block(reg_addr, `ATC_A_CODE, 6'h04)) begin
         rd_mux = {6'h00, code_q[wr_idx[1:0]]};
      end else if (in_block(reg_addr, `ATC_A_IN_GAIN, 6'h08)) begin
         rd_mux = in_gain_pend_q[wr_idx];
      end else if (in_block(reg_addr, `ATC_A_IN_OFS, 6'h08)) begin
         rd_mux = {{8{in_ofs_pend_q[wr_idx][7]}}, in_ofs_pend_q[wr_idx]};
      end else if (in_block(reg_addr, `ATC_A_OUT_GAIN, 6'h04)) begin
         rd_mux = out_gain_q[wr_idx[1:0]];
      end else if (in_block(reg_addr, `ATC_A_OUT_OFS, 6'h04)) begin
         rd_mux = {{8{out_ofs_q[wr_idx[1:0]][7]}}, out_ofs_q[wr_idx[1:0]]};
      end else if (reg_addr == `ATC_A_POINTS) begin
         rd_mux = {12'h000, points_q};
      end else if (reg_addr == `ATC_A_CTRL) begin
         rd_mux = {15'h0000, ~sample_ready};
      end
   end

   // read data stand one cycle only
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;

endmodule

// >>> bench/atc_monitor.sv
`timescale 1ns/1ps
`include "atc_regs.svh"

module atc_monitor (
   input wire logic ref_clk, // clock
   input wire logic reset, // sync reset
   input wire logic [`ATC_REG_AW-1:0] reg_addr, // word address
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [`ATC_REG_DW-1:0] reg_rdata, // read data
   input wire logic sample_valid, // sample offered
   input wire logic sample_ready, // sample taken
   input wire logic [`ATC_DAC_W-1:0] dac_code0, // code ch 0
   input wire logic [`ATC_DAC_W-1:0] dac_code3 // code ch 3
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   //////////////////////////////////////////////////////////////
   // sample hand-off, then a busy span of 2n+1 cycles, n in 1..9
   sequence s_take;
      sample_valid && sample_ready;
   endsequence
   sequence s_busy;
      !sample_ready [*3] ##[1:17] sample_ready;
   endsequence
   chk_busy_span: assert property (s_take |=> s_busy)
      else $error("averager busy span out of range");
   chk_busy_flag: assert property (reg_rd && reg_addr == `ATC_A_CTRL
      |=> reg_rdata[0] == !$past(sample_ready))
      else $error("busy flag disagrees with ready");
   // converter codes move only two edges after a write
   chk_dac_hold: assert property ($changed(dac_code0)
      |-> $past(reg_wr, 2))
      else $error("code moved without a write");
   chk_dac_lag: assert property (reg_wr && reg_addr == `ATC_A_SET
      && !$past(reg_wr) |=> $stable(dac_code0))
      else $error("code moved one edge after set write");
   chk_code_read0: assert property (reg_rd && reg_addr == `ATC_A_CODE
      |=> reg_rdata == {6'h00, $past(dac_code0)})
      else $error("code readback ch 0 wrong");
   chk_code_read3: assert property (reg_rd
      && reg_addr == `ATC_A_CODE + 6'h03
      |=> reg_rdata == {6'h00, $past(dac_code3)})
      else $error("code readback ch 3 wrong");
   // read data shapes
   chk_result_width: assert property (reg_rd && reg_addr < `ATC_A_SET
      |=> reg_rdata[15:12] == 4'h0)
      else $error("input result exceeds 12 bits");
   chk_points_range: assert property (reg_rd
      && reg_addr == `ATC_A_POINTS
      |=> reg_rdata inside {[16'h0001:16'h0009]})
      else $error("point count out of range");
   chk_rdata_idle: assert property (!$past(reg_rd)
      |-> reg_rdata == 16'h0000)
      else $error("read data without a read");
   chk_unmapped_zero: assert property (reg_rd && reg_addr > `ATC_A_CTRL
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule

bind atc_top atc_monitor mon (.ref_clk(ref_clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .sample_valid(sample_valid),
   .sample_ready(sample_ready), .dac_code0(dac_code0),
   .dac_code3(dac_code3));

// >>> bench/atc_sample_src.sv
`timescale 1ns/1ps

module atc_sample_src (
   input wire logic ref_clk, // clock
   input wire logic sample_ready, // sink takes when high
   output logic sample_valid, // sample offered
   output logic [2:0] sample_chan, // input channel
   output logic [11:0] sample_data // raw sample
);
   // idle lines at time zero
   initial begin
      sample_valid = 1'b0;
      sample_chan = 3'h0;
      sample_data = 12'h000;
   end
   //////////////////////////////////////////////////////////////
   // offer one sample, hold until taken, then scramble the lines
   task automatic send(input logic [2:0] ch, input logic [11:0] d);
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      sample_chan <= ch;
      sample_data <= d;
      @(negedge ref_clk);
      while (sample_ready !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      sample_valid <= 1'b0;
      sample_chan <= ~ch;
      sample_data <= ~d;
   endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
`include "atc_regs.svh"

module testbench;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] reg_addr = 6'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic sample_valid;
   logic sample_ready;
   logic [2:0] sample_chan;
   logic [11:0] sample_data;
   logic [9:0] dac [4];
   logic [5:0] oc [5] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h01};
   int ov [5] = '{2048, 2048, 2048, 4095, 10};
   int og [5] = '{0, 81, -60, 200, 0};
   int oo [5] = '{0, 0, 120, 100, -100};
   logic [11:0] av [4] = '{12'd100, 12'd200, 12'd400, 12'd0};
   logic [11:0] t;
   int s;
   int m;
   int n_fail = 0;
   int n_tests = 0;

   always #20 ref_clk = ~ref_clk;

   atc_top dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sample_valid(sample_valid),
      .sample_chan(sample_chan), .sample_data(sample_data),
      .sample_ready(sample_ready), .dac_code0(dac[0]), .dac_code1(dac[1]),
      .dac_code2(dac[2]), .dac_code3(dac[3]));
   atc_sample_src src (.ref_clk(ref_clk), .sample_ready(sample_ready),
      .sample_valid(sample_valid), .sample_chan(sample_chan),
      .sample_data(sample_data));
   //////////////////////////////////////////////////////////////
   // compare, bus cycles, sample hand-off, verdict
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [5:0] a, logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [5:0] a, logic [15:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 check($sformatf("reg %h", a), reg_rdata, exp);
   endtask
   task automatic smp(logic [2:0] ch, logic [11:0] d);
      int k;
      src.send(ch, d);
      k = 0;
      @(negedge ref_clk);
      while (sample_ready !== 1'b1 && k < 40) begin
         @(negedge ref_clk);
         k++;
      end
      check("sample done", {15'h0000, sample_ready}, 16'h0001);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // gain rounded half away, offset clamped, result saturated
   function automatic logic [11:0] trim(int v, int g, int o);
      int p;
      int r;
      p = v * (10000 + g);
      r = (p >= 0) ? (p + 5000) / 10000 : -((5000 - p) / 10000);
      o = (o > 100) ? 100 : ((o < -100) ? -100 : o);
      r = r + o;
      return (r < 0) ? 12'h000 : ((r > 4095) ? 12'hFFF : 12'(r));
   endfunction
   //////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      rd(`ATC_A_POINTS, 16'h0001);
      rd(`ATC_A_SET, 16'h0000);
      rd(`ATC_A_CODE, 16'h0000);
      rd(`ATC_A_CTRL, 16'h0000);
      rd(6'h3F, 16'h0000);
      // output trims per channel, first entries keep offset at 0
      for (int i = 0; i < 5; i++) begin
         wr(`ATC_A_OUT_GAIN + oc[i], 16'(og[i]));
         wr(`ATC_A_OUT_OFS + oc[i], 16'(oo[i]));
         wr(`ATC_A_SET + oc[i], 16'(ov[i]));
         t = trim(ov[i], og[i], oo[i]);
         rd(`ATC_A_CODE + oc[i], {6'h00, t[11:2]});
         check("dac", {6'h00, dac[oc[i]]}, {6'h00, t[11:2]});
      end
      check("dac mid", {6'h00, dac[0]}, 16'h0200);
      rd(`ATC_A_CODE + 6'h03, 16'h03FF);
      // input trims stage until cold boot
      wr(`ATC_A_IN_GAIN, 16'hFFC6);
      wr(`ATC_A_IN_OFS, 16'h0005);
      wr(`ATC_A_IN_OFS + 6'h03, 16'h0064);
      smp(3'h0, 12'd2060);
      rd(`ATC_A_RESULT, 16'd2060);
      wr(`ATC_A_CTRL, 16'h0001);
      smp(3'h0, 12'd2060);
      rd(`ATC_A_RESULT, {4'h0, trim(2060, -58, 5)});
      smp(3'h0, 12'd1000);
      rd(`ATC_A_RESULT, {4'h0, trim(1000, -58, 5)});
      smp(3'h3, 12'hFF0);
      rd(`ATC_A_RESULT + 6'h03, 16'h0FFF);
      // point count limits, then a three point moving average
      wr(`ATC_A_POINTS, 16'h0000);
      rd(`ATC_A_POINTS, 16'h0001);
      wr(`ATC_A_POINTS, 16'h000F);
      rd(`ATC_A_POINTS, 16'h0009);
      wr(`ATC_A_POINTS, 16'h0003);
      for (int i = 0; i < 4; i++) begin
         smp(3'h2, av[i]);
         s = 0;
         m = 0;
         for (int j = i; j >= 0 && j > i - 3; j--) begin
            s += av[j];
            m++;
         end
         rd(`ATC_A_RESULT + 6'h02, 16'((s + m / 2) / m));
      end
      rd(`ATC_A_RESULT, {4'h0, trim(1000, -58, 5)});
      // nine point average wraps the history of channel 4
      wr(`ATC_A_POINTS, 16'h0009);
      for (int i = 0; i < 10; i++) begin
         smp(3'h4, 12'(i * 100));
      end
      rd(`ATC_A_RESULT + 6'h04, 16'd500);
      // trim and set readback
      rd(`ATC_A_OUT_OFS + 6'h01, 16'hFF9C);
      rd(`ATC_A_IN_GAIN, 16'hFFC6);
      rd(`ATC_A_SET + 6'h03, 16'h0FFF);
      end_of_test();
   end
   // watchdog
   initial begin
      #200000;
      n_fail++;
      end_of_test();
   end
endmodule
